// [design/pmc_pkg.sv]
// ==========================================================
// Shared constants and types of the power and clock block.
package pmc_pkg;
  // Register byte offsets.
  localparam logic [7:0]  A_PLL  = 8'h00;
  localparam logic [7:0]  A_DIV  = 8'h04;
  localparam logic [7:0]  A_VR   = 8'h08;
  localparam logic [7:0]  A_LCK  = 8'h0c;
  localparam logic [7:0]  A_STAT = 8'h10;
  // Field positions.
  localparam int          CDIV_LSB = 4;
  localparam int          VLEV_LSB = 4;
  localparam int          MODE_LSB = 9;
  // Values after reset, and the regulator switch-off code.
  localparam logic [5:0]  MULT_RST = 6'h0a;
  localparam logic [3:0]  SDIV_RST = 4'h5;
  localparam logic [1:0]  CDIV_RST = 2'h0;
  localparam logic [3:0]  VLEV_RST = 4'h5;
  localparam logic [1:0]  RSW_RST  = 2'h3;
  localparam logic [1:0]  RSW_OFF  = 2'h0;
  localparam logic [15:0] LOCK_RST = 16'h0200;
  // Regulator steps in millivolts.
  localparam int          VSTEP_MV = 50;
  localparam int          VMIN_MV  = 850;
  localparam int          VMAX_MV  = 1300;
  localparam logic [3:0]  VLEV_MAX = 4'((VMAX_MV - VMIN_MV) / VSTEP_MV);
  // Settling time, longest time, rounded down to cycles.
  localparam int          CLK_MHZ    = 40;
  localparam int          SETTLE_US  = 40;
  localparam logic [12:0] SETTLE_CYC = 13'(SETTLE_US * CLK_MHZ);
  // Mode request codes in the PLL control register.
  localparam logic [1:0]  REQ_SLEEP = 2'h1;
  localparam logic [1:0]  REQ_DEEP  = 2'h2;
  // PLL control register layout.
  typedef struct packed {
    logic [1:0] mode_req;
    logic       pll_off;
    logic       bypass;
    logic       half;
    logic [5:0] mult;
  } pll_control_reg_t;
  // Mode states, Gray along full-on, active, sleep, deep sleep, hibernate.
  typedef enum logic [2:0] {
    ST_FULL  = 3'b000,
    ST_ACT   = 3'b001,
    ST_SLEEP = 3'b011,
    ST_DEEP  = 3'b010,
    ST_HIB   = 3'b110,
    ST_LOCK  = 3'b111,
    ST_BOOT  = 3'b101
  } state_t;
endpackage

// [design/power_mode_clock_divider_ctrl.sv]
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module power_mode_clock_divider_ctrl (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        ref_clock_input_i,
  input  wire logic        wake_i,
  input  wire logic        reset_wake_i,
  output logic             core_clk_en_o,
  output logic             sys_clk_en_o,
  output logic             periph_block_o,
  output logic             pins_tristate_o,
  output logic             regulator_on_o,
  output logic      [3:0]  vlevel_o,
  output logic             boot_start_o
);
  // ==========================================================
  // Pin synchronisers: a change counts when stages two and three agree.
  logic [2:0] ref_sync_reg, wake_sync_reg, rwk_sync_reg;
  logic       ref_lvl_reg, wake_lvl_reg, rwk_lvl_reg;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_sync_reg  <= 3'h0;
      wake_sync_reg <= 3'h0;
      rwk_sync_reg  <= 3'h0;
      ref_lvl_reg   <= 1'b0;
      wake_lvl_reg  <= 1'b0;
      rwk_lvl_reg   <= 1'b0;
    end else begin
      ref_sync_reg  <= {ref_sync_reg[1:0], ref_clock_input_i};
      wake_sync_reg <= {wake_sync_reg[1:0], wake_i};
      rwk_sync_reg  <= {rwk_sync_reg[1:0], reset_wake_i};
      if (ref_sync_reg[1] == ref_sync_reg[2]) ref_lvl_reg <= ref_sync_reg[2];
      if (wake_sync_reg[1] == wake_sync_reg[2]) wake_lvl_reg <= wake_sync_reg[2];
      if (rwk_sync_reg[1] == rwk_sync_reg[2]) rwk_lvl_reg <= rwk_sync_reg[2];
    end
  end
  logic ref_rise;
  assign ref_rise = (ref_sync_reg[1] == ref_sync_reg[2]) && ref_sync_reg[2] && !ref_lvl_reg;

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY.
  logic       wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic       acc;
  assign acc = hsel_i && hready_i && htrans_i[1];
  pmc_pkg::pll_control_reg_t pll_reg;
  logic [3:0]  sdiv_reg;
  logic [1:0]  cdiv_reg;
  logic [1:0]  rsw_reg;
  logic [3:0]  vlev_reg;
  logic [15:0] lock_reg;
  pmc_pkg::state_t state_reg;
  logic        lock_done;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      wr_pend_reg <= acc && hwrite_i;
      if (acc) wr_addr_reg <= haddr_i;
      if (acc && !hwrite_i) begin
        case (haddr_i)
          pmc_pkg::A_PLL:  hrdata_o <= {21'h0, pll_reg};
          pmc_pkg::A_DIV:  hrdata_o <= {26'h0, cdiv_reg, sdiv_reg};
          pmc_pkg::A_VR:   hrdata_o <= {24'h0, vlev_reg, 2'h0, rsw_reg};
          pmc_pkg::A_LCK:  hrdata_o <= {16'h0, lock_reg};
          pmc_pkg::A_STAT: hrdata_o <= {28'h0, lock_done, state_reg};
          default:         hrdata_o <= 32'h0;
        endcase
      end
    end
  end
  logic wr_pll, wr_div, wr_vr, wr_lck;
  assign wr_pll = wr_pend_reg && (wr_addr_reg == pmc_pkg::A_PLL);
  assign wr_div = wr_pend_reg && (wr_addr_reg == pmc_pkg::A_DIV);
  assign wr_vr  = wr_pend_reg && (wr_addr_reg == pmc_pkg::A_VR);
  assign wr_lck = wr_pend_reg && (wr_addr_reg == pmc_pkg::A_LCK);
  pmc_pkg::pll_control_reg_t new_pll;
  logic [3:0] new_vlev;
  assign new_pll  = pmc_pkg::pll_control_reg_t'(hwdata_i[10:0]);
  assign new_vlev = hwdata_i[pmc_pkg::VLEV_LSB +: 4];
  logic mult_chg, vlev_chg;
  assign mult_chg = wr_pll && ({new_pll.half, new_pll.mult} != {pll_reg.half, pll_reg.mult});
  assign vlev_chg = wr_vr && (new_vlev <= pmc_pkg::VLEV_MAX) && (new_vlev != vlev_reg);

  // ==========================================================
  // Control registers. A voltage code above the top step is ignored.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pll_reg  <= '{mode_req: 2'h0, pll_off: 1'b0, bypass: 1'b0, half: 1'b0,
                    mult: pmc_pkg::MULT_RST};
      sdiv_reg <= pmc_pkg::SDIV_RST;
      cdiv_reg <= pmc_pkg::CDIV_RST;
      rsw_reg  <= pmc_pkg::RSW_RST;
      vlev_reg <= pmc_pkg::VLEV_RST;
    end else begin
      if (wr_pll) pll_reg <= '{mode_req: 2'h0, pll_off: new_pll.pll_off,
                               bypass: new_pll.bypass, half: new_pll.half,
                               mult: new_pll.mult};
      if (wr_div && hwdata_i[3:0] != 4'h0) sdiv_reg <= hwdata_i[3:0];
      if (wr_div) cdiv_reg <= hwdata_i[pmc_pkg::CDIV_LSB +: 2];
      if (wr_vr) rsw_reg <= hwdata_i[1:0];
      if (vlev_chg) vlev_reg <= new_vlev;
      if (state_reg == pmc_pkg::ST_BOOT) rsw_reg <= pmc_pkg::RSW_RST;
    end
  end

  // ==========================================================
  // Lock wait: reference clock periods, plus a 40 us floor per change.
  logic [15:0] lock_cnt_reg;
  logic [12:0] settle_reg;
  logic [1:0]  chg_reg;
  assign lock_done = (lock_cnt_reg == 16'h0) && (settle_reg == 13'h0) && (chg_reg == 2'h0);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_reg     <= pmc_pkg::LOCK_RST;
      lock_cnt_reg <= 16'h0;
      settle_reg   <= 13'h0;
      chg_reg      <= 2'h0;
    end else begin
      if (wr_lck) lock_reg <= hwdata_i[15:0];
      if (mult_chg || vlev_chg || rwk_lvl_reg && state_reg == pmc_pkg::ST_HIB) begin
        lock_cnt_reg <= lock_reg;
        settle_reg   <= pmc_pkg::SETTLE_CYC;
        // A second settle period only when both change at once; a wake needs one.
        chg_reg      <= 2'(mult_chg && vlev_chg);
      end else begin
        if (ref_rise && lock_cnt_reg != 16'h0) lock_cnt_reg <= lock_cnt_reg - 16'h1;
        if (settle_reg != 13'h0) settle_reg <= settle_reg - 13'h1;
        else if (chg_reg != 2'h0) begin
          settle_reg <= pmc_pkg::SETTLE_CYC;
          chg_reg    <= chg_reg - 2'h1;
        end
      end
    end
  end

  // ==========================================================
  // Mode machine. Deep sleep answers only the reset wake pin.
  logic bypass_eff;
  assign bypass_eff = pll_reg.bypass;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg    <= pmc_pkg::ST_FULL;
      boot_start_o <= 1'b0;
    end else begin
      boot_start_o <= 1'b0;
      case (state_reg)
        pmc_pkg::ST_FULL, pmc_pkg::ST_ACT: begin
          if (wr_vr && hwdata_i[1:0] == pmc_pkg::RSW_OFF) state_reg <= pmc_pkg::ST_HIB;
          else if (mult_chg || vlev_chg) state_reg <= pmc_pkg::ST_LOCK;
          else if (wr_pll && new_pll.mode_req == pmc_pkg::REQ_DEEP) state_reg <= pmc_pkg::ST_DEEP;
          else if (wr_pll && new_pll.mode_req == pmc_pkg::REQ_SLEEP) state_reg <= pmc_pkg::ST_SLEEP;
          else if (wr_pll) state_reg <= new_pll.bypass ? pmc_pkg::ST_ACT : pmc_pkg::ST_FULL;
        end
        pmc_pkg::ST_SLEEP: begin
          if (wake_lvl_reg || rwk_lvl_reg)
            state_reg <= bypass_eff ? pmc_pkg::ST_ACT : pmc_pkg::ST_FULL;
        end
        pmc_pkg::ST_DEEP: begin
          if (rwk_lvl_reg) state_reg <= bypass_eff ? pmc_pkg::ST_ACT : pmc_pkg::ST_FULL;
        end
        pmc_pkg::ST_HIB: begin
          if (rwk_lvl_reg) state_reg <= pmc_pkg::ST_LOCK;
        end
        pmc_pkg::ST_LOCK: begin
          if (lock_done) begin
            state_reg    <= (rsw_reg == pmc_pkg::RSW_OFF) ? pmc_pkg::ST_BOOT
                          : bypass_eff ? pmc_pkg::ST_ACT : pmc_pkg::ST_FULL;
          end
        end
        pmc_pkg::ST_BOOT: begin
          boot_start_o <= 1'b1;
          state_reg    <= bypass_eff ? pmc_pkg::ST_ACT : pmc_pkg::ST_FULL;
        end
        default: state_reg <= pmc_pkg::ST_FULL;
      endcase
    end
  end

  // ==========================================================
  // Dividers. The oscillator tick is mclk, or the reference edge under
  // bypass. New ratios load only at wrap, so no pulse is ever shortened.
  logic       tick;
  logic [3:0] sys_cnt_reg, sys_div_reg;
  logic [2:0] core_cnt_reg;
  logic [1:0] core_sel_reg;
  assign tick = bypass_eff ? ref_rise : 1'b1;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sys_cnt_reg  <= 4'h0;
      sys_div_reg  <= pmc_pkg::SDIV_RST;
      core_cnt_reg <= 3'h0;
      core_sel_reg <= pmc_pkg::CDIV_RST;
    end else if (tick) begin
      if (bypass_eff || sys_cnt_reg >= sys_div_reg - 4'h1) begin
        sys_cnt_reg <= 4'h0;
        sys_div_reg <= sdiv_reg;
      end else sys_cnt_reg <= sys_cnt_reg + 4'h1;
      if (bypass_eff || core_cnt_reg >= 3'((4'h1 << core_sel_reg) - 4'h1)) begin
        core_cnt_reg <= 3'h0;
        core_sel_reg <= cdiv_reg;
      end else core_cnt_reg <= core_cnt_reg + 3'h1;
    end
  end
  logic run_core, run_sys, sys_wrap, core_wrap;
  assign sys_wrap  = bypass_eff || sys_cnt_reg >= sys_div_reg - 4'h1;
  assign core_wrap = bypass_eff || core_cnt_reg >= 3'((4'h1 << core_sel_reg) - 4'h1);
  assign run_core  = state_reg == pmc_pkg::ST_FULL || state_reg == pmc_pkg::ST_ACT;
  assign run_sys   = run_core || state_reg == pmc_pkg::ST_SLEEP;

  // ==========================================================
  // Clock enables and power outputs, all registered.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_clk_en_o   <= 1'b0;
      sys_clk_en_o    <= 1'b0;
      periph_block_o  <= 1'b0;
      pins_tristate_o <= 1'b0;
      regulator_on_o  <= 1'b1;
      vlevel_o        <= pmc_pkg::VLEV_RST;
    end else begin
      core_clk_en_o   <= run_core && tick && core_wrap;
      sys_clk_en_o    <= run_sys && tick && sys_wrap;
      periph_block_o  <= state_reg == pmc_pkg::ST_DEEP || state_reg == pmc_pkg::ST_HIB;
      pins_tristate_o <= state_reg == pmc_pkg::ST_HIB;
      regulator_on_o  <= state_reg != pmc_pkg::ST_HIB;
      vlevel_o        <= vlev_reg;
    end
  end

  // ==========================================================
  // Checks.
  property p_deep_gated;
    @(posedge mclk_i) disable iff (!rstn_i)
      state_reg == pmc_pkg::ST_DEEP |=> !core_clk_en_o && !sys_clk_en_o && periph_block_o;
  endproperty
  a_deep_gated: assert property (p_deep_gated) else $error("clock in deep sleep");
  property p_deep_exit;
    @(posedge mclk_i) disable iff (!rstn_i)
      $past(state_reg) == pmc_pkg::ST_DEEP && state_reg != pmc_pkg::ST_DEEP |-> $past(rwk_lvl_reg);
  endproperty
  a_deep_exit: assert property (p_deep_exit) else $error("deep sleep left early");
  property p_deep_mode;
    @(posedge mclk_i) disable iff (!rstn_i)
      state_reg == pmc_pkg::ST_DEEP && rwk_lvl_reg && !bypass_eff |=> state_reg == pmc_pkg::ST_FULL;
  endproperty
  a_deep_mode: assert property (p_deep_mode) else $error("wrong wake mode");
  property p_hib;
    @(posedge mclk_i) disable iff (!rstn_i)
      state_reg == pmc_pkg::ST_HIB |=> pins_tristate_o && !regulator_on_o && !sys_clk_en_o;
  endproperty
  a_hib: assert property (p_hib) else $error("hibernate outputs wrong");
  property p_hib_wake;
    @(posedge mclk_i) disable iff (!rstn_i)
      state_reg == pmc_pkg::ST_HIB && rwk_lvl_reg |=> state_reg == pmc_pkg::ST_LOCK;
  endproperty
  a_hib_wake: assert property (p_hib_wake) else $error("hibernate wake skipped lock");
  // The lock wait can outlast any bounded range, so boot is checked from its end.
  property p_boot;
    @(posedge mclk_i) disable iff (!rstn_i)
      state_reg == pmc_pkg::ST_LOCK && lock_done && rsw_reg == pmc_pkg::RSW_OFF
      |=> state_reg == pmc_pkg::ST_BOOT ##1 boot_start_o;
  endproperty
  a_boot: assert property (p_boot) else $error("no boot after hibernate");
  property p_vmax;
    @(posedge mclk_i) disable iff (!rstn_i) vlev_reg <= pmc_pkg::VLEV_MAX;
  endproperty
  a_vmax: assert property (p_vmax) else $error("voltage code out of range");
  property p_lock_gate;
    @(posedge mclk_i) disable iff (!rstn_i)
      state_reg == pmc_pkg::ST_LOCK && !lock_done |=> !core_clk_en_o && !sys_clk_en_o;
  endproperty
  a_lock_gate: assert property (p_lock_gate) else $error("clock during lock wait");
  property p_sleep;
    @(posedge mclk_i) disable iff (!rstn_i)
      state_reg == pmc_pkg::ST_SLEEP |=> !core_clk_en_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("core clock in sleep");
  property p_core_div1;
    @(posedge mclk_i) disable iff (!rstn_i)
      run_core && !bypass_eff && core_sel_reg == 2'h0 && $stable(state_reg) |=> core_clk_en_o;
  endproperty
  a_core_div1: assert property (p_core_div1) else $error("core divide by one broken");
  c_deep:  cover property (@(posedge mclk_i) state_reg == pmc_pkg::ST_DEEP ##1 state_reg == pmc_pkg::ST_FULL);
  c_hib:   cover property (@(posedge mclk_i) boot_start_o);
  c_lock:  cover property (@(posedge mclk_i) state_reg == pmc_pkg::ST_LOCK && lock_done);
  c_sleep: cover property (@(posedge mclk_i) state_reg == pmc_pkg::ST_SLEEP ##1 state_reg == pmc_pkg::ST_ACT);
endmodule

// [tb/power_mode_clock_divider_ctrl_tb.sv]
`timescale 1ns/1ps
module power_mode_clock_divider_ctrl_tb;
  logic        mclk_i            = 1'b0;
  logic        rstn_i            = 1'b0;
  logic        hsel_i            = 1'b0;
  logic [7:0]  haddr_i           = 8'h00;
  logic [1:0]  htrans_i          = 2'h0;
  logic        hwrite_i          = 1'b0;
  logic [2:0]  hsize_i           = 3'h2;
  logic [31:0] hwdata_i          = 32'h0;
  logic        ref_clock_input_i = 1'b0;
  logic        wake_i            = 1'b0;
  logic        reset_wake_i      = 1'b0;
  logic        hready_i;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        core_clk_en_o;
  logic        sys_clk_en_o;
  logic        periph_block_o;
  logic        pins_tristate_o;
  logic        regulator_on_o;
  logic [3:0]  vlevel_o;
  logic        boot_start_o;
  logic [31:0] rd;
  int          fails    = 0;
  int          compares = 0;
  int          cycles   = 0;
  int          c;
  int          n;

  // The one slave on the bus, so its ready is the bus ready.
  assign hready_i = hreadyout_o;

  power_mode_clock_divider_ctrl dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .ref_clock_input_i(ref_clock_input_i), .wake_i(wake_i),
    .reset_wake_i(reset_wake_i), .core_clk_en_o(core_clk_en_o), .sys_clk_en_o(sys_clk_en_o),
    .periph_block_o(periph_block_o), .pins_tristate_o(pins_tristate_o),
    .regulator_on_o(regulator_on_o), .vlevel_o(vlevel_o), .boot_start_o(boot_start_o));

  // ==========================================================
  // Clocks and watchdog.
  // The reference clock is four system clocks long and its edges fall on falling system edges, never on rising ones.
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  initial begin
    forever #50 ref_clock_input_i = ~ref_clock_input_i;
  end
  // A hung wait is cut short so the run always reaches its verdict.
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails = fails + 1;
      end_sim();
    end
  end

  // ==========================================================
  // Shared tasks.
  task automatic end_sim();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // The master never assumes a latency; it waits for ready under a bound.
  task automatic rdy();
    int k;
    k = 0;
    @(posedge mclk_i);
    while (hready_i !== 1'b1 && k < 100) begin
      @(posedge mclk_i);
      k++;
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    rdy();
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    rdy();
    rd = hrdata_o;
  endtask
  // One spare edge lets the register land before anything reads it back.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
    @(posedge mclk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic st(input pmc_pkg::state_t s);
    ahb(1'b0, pmc_pkg::A_STAT, 32'h0);
    chk({29'h0, rd[2:0]}, {29'h0, s});
  endtask
  function automatic logic en(input bit core);
    return core ? core_clk_en_o : sys_clk_en_o;
  endfunction
  task automatic cnt(input bit core, input int len);
    c = 0;
    repeat (len) begin
      @(posedge mclk_i);
      if (en(core) === 1'b1) c++;
    end
  endtask
  // Third gap between pulses, so a divisor loaded at the period wrap is in force.
  task automatic per(input bit core);
    repeat (3) begin
      n = 0;
      do begin
        @(posedge mclk_i);
        n++;
      end while (en(core) !== 1'b1 && n < 300);
    end
  endtask
  task automatic gap(input bit boot);
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while ((boot ? boot_start_o : core_clk_en_o) !== 1'b1 && n < 3000);
  endtask
  // Pulse one wake pin long enough to pass the synchroniser and settle back.
  task automatic pin(input bit rwk);
    if (rwk) reset_wake_i <= 1'b1;
    else wake_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    reset_wake_i <= 1'b0;
    wake_i       <= 1'b0;
    repeat (6) @(posedge mclk_i);
  endtask

  // ==========================================================
  // Scenarios.
  task automatic t_reset();
    chk({29'h0, hreadyout_o, regulator_on_o, hresp_o}, 32'h6);
    chk({28'h0, vlevel_o}, 32'h5);
    rdc(pmc_pkg::A_PLL, 32'h0000000a);
    rdc(pmc_pkg::A_DIV, 32'h00000005);
    rdc(pmc_pkg::A_VR, 32'h00000053);
    rdc(pmc_pkg::A_LCK, 32'h00000200);
    st(pmc_pkg::ST_FULL);
    wr(8'h20, 32'hffffffff);
    rdc(8'h20, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_div();
    wr(pmc_pkg::A_DIV, 32'h00000023);
    per(1'b0);
    chk(n, 3);
    per(1'b1);
    chk(n, 4);
    st(pmc_pkg::ST_FULL);
    for (int i = 0; i < 4; i++) begin
      wr(pmc_pkg::A_DIV, 32'h0f | (i << pmc_pkg::CDIV_LSB));
      per(1'b1);
      chk(n, 1 << i);
    end
    per(1'b0);
    chk(n, 15);
    wr(pmc_pkg::A_DIV, 32'h0);
    rdc(pmc_pkg::A_DIV, 32'h0f);
    wr(pmc_pkg::A_DIV, 32'h01);
    $display("test dividers done");
  endtask
  task automatic t_modes();
    wr(pmc_pkg::A_PLL, 32'h20a);
    st(pmc_pkg::ST_SLEEP);
    rdc(pmc_pkg::A_PLL, 32'h0a);
    cnt(1'b1, 50);
    chk(c, 0);
    cnt(1'b0, 50);
    chk(c, 50);
    pin(1'b0);
    st(pmc_pkg::ST_FULL);
    wr(pmc_pkg::A_PLL, 32'h40a);
    st(pmc_pkg::ST_DEEP);
    cnt(1'b1, 50);
    chk(c, 0);
    cnt(1'b0, 50);
    chk(c, 0);
    chk(periph_block_o, 1'b1);
    pin(1'b0);
    st(pmc_pkg::ST_DEEP);
    pin(1'b1);
    st(pmc_pkg::ST_FULL);
    chk(periph_block_o, 1'b0);
    wr(pmc_pkg::A_PLL, 32'h08a);
    st(pmc_pkg::ST_ACT);
    cnt(1'b1, 400);
    chk(c >= 99 && c <= 101, 1'b1);
    wr(pmc_pkg::A_PLL, 32'h48a);
    st(pmc_pkg::ST_DEEP);
    pin(1'b1);
    st(pmc_pkg::ST_ACT);
    wr(pmc_pkg::A_PLL, 32'h00a);
    st(pmc_pkg::ST_FULL);
    $display("test modes done");
  endtask
  task automatic t_lock();
    wr(pmc_pkg::A_VR, 32'h73);
    // The voltage output register trails the stored code by one edge.
    @(posedge mclk_i);
    chk({28'h0, vlevel_o}, 32'h7);
    st(pmc_pkg::ST_LOCK);
    gap(1'b0);
    chk(n >= 2030 && n <= 2130, 1'b1);
    wr(pmc_pkg::A_VR, 32'ha3);
    @(posedge mclk_i);
    chk({28'h0, vlevel_o}, 32'h7);
    wr(pmc_pkg::A_LCK, 32'h10);
    wr(pmc_pkg::A_PLL, 32'h10);
    gap(1'b0);
    chk(n >= 1590 && n <= 1700, 1'b1);
    rdc(pmc_pkg::A_PLL, 32'h10);
    $display("test lock done");
  endtask
  task automatic t_hib();
    wr(pmc_pkg::A_VR, 32'h70);
    repeat (2) @(posedge mclk_i);
    chk({29'h0, pins_tristate_o, regulator_on_o, periph_block_o}, 32'h5);
    cnt(1'b1, 40);
    chk(c, 0);
    cnt(1'b0, 40);
    chk(c, 0);
    reset_wake_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    reset_wake_i <= 1'b0;
    gap(1'b1);
    chk(n >= 1580 && n <= 1720, 1'b1);
    chk(regulator_on_o, 1'b1);
    repeat (4) @(posedge mclk_i);
    st(pmc_pkg::ST_FULL);
    $display("test hibernate done");
  endtask

  initial begin
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    t_reset();
    t_div();
    t_modes();
    t_lock();
    t_hib();
    end_sim();
  end
endmodule
